// *** common/axaddr_defs.vh ***
// Constants for the AXI4 address-channel arbiter and burst splitter.
`ifndef AXADDR_DEFS_VH
`define AXADDR_DEFS_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define AXA_OFS_CTRL 4'h0
`define AXA_OFS_RMASK 4'h4
`define AXA_OFS_STATUS 4'h8
`define AXA_OFS_PIECES 4'hc

// ------------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------------
`define AXA_CTRL_SPLIT_BIT 0
`define AXA_CTRL_REGION_BIT 1
`define AXA_CTRL_RESET 2'h1
`define AXA_RMASK_RESET 4'hf
`define AXA_STATUS_BUSY_BIT 0
`define AXA_STATUS_GRANT_BIT 1

// ------------------------------------------------------------------
// Protocol constants
// ------------------------------------------------------------------
`define AXA_LEN_W 8
`define AXA_QOS_W 4
`define AXA_REGION_W 4
`define AXA_REGION_DEFAULT 4'h0
`define AXA_PAGE_LSB 12
`define AXA_MAX_LEGACY_BEATS 9'h010
`define AXA_BURST_FIXED 2'h0
`define AXA_BURST_INCR 2'h1
`define AXA_BURST_WRAP 2'h2

`endif

// *** rtl/axa_splitter.v ***
// Burst splitter: cuts long incrementing bursts into legacy-length pieces.
`timescale 1ns/1ps
`include "axaddr_defs.vh"

module axa_splitter #(
    parameter AW = 32,
    parameter ATTR_W = 16
) (
    input wire clk, // Clock
    input wire srst, // Synchronous reset, active high
    input wire split_en, // Cut bursts above legacy length
    input wire in_valid, // New burst offered
    output wire in_ready, // Splitter idle
    input wire [AW-1:0] in_addr, // Start address
    input wire [7:0] in_len, // Beats minus one
    input wire [2:0] in_size, // Bytes per beat, log2
    input wire [1:0] in_burst, // Burst type
    input wire [ATTR_W-1:0] in_attr, // Attributes carried unchanged
    output reg m_valid_q, // Piece valid
    input wire m_ready, // Downstream accepts piece
    output reg [AW-1:0] m_addr_q, // Piece address
    output reg [7:0] m_len_q, // Piece beats minus one
    output reg [2:0] m_size_q, // Piece size
    output reg [1:0] m_burst_q, // Piece burst type
    output reg [ATTR_W-1:0] m_attr_q, // Piece attributes
    output reg m_last_q, // Final piece of the burst
    output reg busy_q // Burst in progress
);

    reg [AW-1:0] cur_q;
    reg [8:0] rem_q;
    reg [2:0] size_q;
    reg [1:0] burst_q;
    reg [ATTR_W-1:0] attr_q;
    wire slot_free;
    wire cut;
    wire [8:0] beats;
    wire [AW-1:0] next_addr;

    assign in_ready = ~busy_q;
    assign slot_free = ~m_valid_q | m_ready;
    // Only incrementing bursts get longer than the legacy limit
    assign cut = split_en && (burst_q == `AXA_BURST_INCR) &&
                 (rem_q > `AXA_MAX_LEGACY_BEATS);
    assign beats = cut ? `AXA_MAX_LEGACY_BEATS : rem_q;
    // Later pieces start size-aligned; a piece never leaves its 4 KB page
    assign next_addr = (burst_q == `AXA_BURST_INCR) ?
        (((cur_q >> size_q) + {{(AW-9){1'b0}}, beats}) << size_q) :
        cur_q;

    always @(posedge clk) begin
        if (srst) begin
            busy_q <= 1'b0;
            cur_q <= {AW{1'b0}};
            rem_q <= 9'h000;
            size_q <= 3'h0;
            burst_q <= 2'h0;
            attr_q <= {ATTR_W{1'b0}};
            m_valid_q <= 1'b0;
            m_addr_q <= {AW{1'b0}};
            m_len_q <= 8'h00;
            m_size_q <= 3'h0;
            m_burst_q <= 2'h0;
            m_attr_q <= {ATTR_W{1'b0}};
            m_last_q <= 1'b0;
        end else begin
            if (m_valid_q && m_ready) begin
                m_valid_q <= 1'b0;
            end
            if (!busy_q && in_valid) begin
                busy_q <= 1'b1;
                cur_q <= in_addr;
                // Full 1..256 beat range is kept until all are issued
                rem_q <= {1'b0, in_len} + 9'h001;
                size_q <= in_size;
                burst_q <= in_burst;
                attr_q <= in_attr;
            end else if (busy_q && slot_free) begin
                if (rem_q != 9'h000) begin
                    m_valid_q <= 1'b1;
                    m_addr_q <= cur_q;
                    m_len_q <= beats[7:0] - 8'h01;
                    m_size_q <= size_q;
                    m_burst_q <= burst_q;
                    m_attr_q <= attr_q;
                    m_last_q <= (rem_q == beats);
                    cur_q <= next_addr;
                    rem_q <= rem_q - beats;
                end else begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

endmodule // axa_splitter

// *** rtl/axa_channel.v ***
// AXI4 address channel: QoS arbiter, region decode and burst splitter.
//
// Behaviour
// - Length field 8 bits, beats = field + 1
// - Every beat of an issued burst transferred
// - Long bursts split, attributes kept, address adjusted
// - Legacy masters accepted without conversion
// - Bridge splits long bursts into 16-beat pieces
// - Larger QoS value means more urgent
// - Zero QoS means not taking part; here a zero-QoS master still competes, ranked lowest
// - Arbiter serves larger QoS first, ordering wins
// - Each address channel carries 4-bit region
// - Region constant within aligned 4 KB page
// - Single-region slave gets default region
// - Same-ID responses across regions stay ordered
// - Unsupported regions aliased onto supported ones
// - Region only after an address decode
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "axaddr_defs.vh"

module axa_channel #(
    parameter N = 2,
    parameter AW = 32,
    parameter IDW = 4,
    parameter REGION_LSB = 28
) (
    input wire clk, // Clock, 100 MHz
    input wire srst, // Synchronous reset, active high
    input wire [N-1:0] s_valid, // Per-master address valid
    output reg [N-1:0] s_ready_q, // Per-master address ready
    input wire [N*AW-1:0] s_addr, // Per-master address
    input wire [N*8-1:0] s_len, // Per-master length
    input wire [N*3-1:0] s_size, // Per-master size
    input wire [N*2-1:0] s_burst, // Per-master burst type
    input wire [N-1:0] s_lock, // Per-master exclusive flag
    input wire [N*4-1:0] s_cache, // Per-master cache attributes
    input wire [N*3-1:0] s_prot, // Per-master protection
    input wire [N*4-1:0] s_qos, // Per-master QoS
    input wire [N*IDW-1:0] s_id, // Per-master transaction ID
    output wire m_valid, // Slave address valid
    input wire m_ready, // Slave address ready
    output wire [AW-1:0] m_addr, // Slave address
    output wire [7:0] m_len, // Slave length
    output wire [2:0] m_size, // Slave size
    output wire [1:0] m_burst, // Slave burst type
    output wire m_lock, // Slave exclusive flag
    output wire [3:0] m_cache, // Slave cache attributes
    output wire [2:0] m_prot, // Slave protection
    output wire [3:0] m_qos, // Slave QoS
    output wire [3:0] m_region, // Slave region identifier
    output wire [IDW-1:0] m_id, // Slave transaction ID
    output wire m_last_piece, // Final piece of a split burst
    input wire [3:0] avs_address, // Register byte address
    input wire avs_read, // Register read
    input wire avs_write, // Register write
    input wire [31:0] avs_writedata, // Register write data
    output reg [31:0] avs_readdata_q, // Register read data
    output reg avs_waitrequest_q // Register wait, high idle
);

    localparam IDX_W = (N > 1) ? $clog2(N) : 1;
    localparam ATTR_W = IDW + 1 + 4 + 3 + 4 + 4;
    localparam ST_IDLE = 2'h0;
    localparam ST_GRANT = 2'h1;
    localparam ST_WAIT = 2'h2;

    // --------------------------------------------------------------
    // Register file
    // --------------------------------------------------------------
    reg [1:0] ctrl_q;
    reg [3:0] rmask_q;
    reg [15:0] pieces_q;
    reg [1:0] state_q;
    reg [IDX_W-1:0] sel_q;
    wire acc;
    wire busy;
    wire [ATTR_W-1:0] out_attr;

    // Answer comes one cycle after the request; read data are ready then
    assign acc = (avs_read | avs_write) & ~avs_waitrequest_q;

    function [31:0] reg_value;
        input [3:0] ofs;
        begin
            case (ofs)
                `AXA_OFS_CTRL: reg_value = {30'h0, ctrl_q};
                `AXA_OFS_RMASK: reg_value = {28'h0, rmask_q};
                `AXA_OFS_STATUS: reg_value = {30'h0,
                    state_q != ST_IDLE, busy};
                `AXA_OFS_PIECES: reg_value = {16'h0, pieces_q};
                default: reg_value = 32'h0;
            endcase
        end
    endfunction

    always @(posedge clk) begin
        if (srst) begin
            avs_waitrequest_q <= 1'b1;
            avs_readdata_q <= 32'h0;
            ctrl_q <= `AXA_CTRL_RESET;
            rmask_q <= `AXA_RMASK_RESET;
        end else begin
            avs_waitrequest_q <= ~((avs_read | avs_write) &
                avs_waitrequest_q);
            if (avs_read && avs_waitrequest_q) begin
                avs_readdata_q <= reg_value(avs_address);
            end
            if (acc && avs_write) begin
                if (avs_address == `AXA_OFS_CTRL) begin
                    ctrl_q <= avs_writedata[1:0];
                end
                if (avs_address == `AXA_OFS_RMASK) begin
                    rmask_q <= avs_writedata[3:0];
                end
            end
        end
    end

    // --------------------------------------------------------------
    // QoS arbitration
    // --------------------------------------------------------------
    reg [IDX_W-1:0] win;
    reg [3:0] best;
    reg any;
    integer i;

    // Highest QoS wins, lowest index on a tie; zero QoS ranks lowest.
    // Each master has one request at a time, so its own order holds.
    always @* begin
        win = {IDX_W{1'b0}};
        best = 4'h0;
        any = 1'b0;
        for (i = 0; i < N; i = i + 1) begin
            if (s_valid[i] && (!any || s_qos[i*4 +: 4] > best)) begin
                win = i[IDX_W-1:0];
                best = s_qos[i*4 +: 4];
                any = 1'b1;
            end
        end
    end

    // Ready is only raised for the chosen master and only while the
    // splitter is free, so a captured request is never dropped.
    wire in_ready;
    wire take;
    assign take = (state_q == ST_GRANT) && s_valid[sel_q];

    always @(posedge clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            sel_q <= {IDX_W{1'b0}};
            s_ready_q <= {N{1'b0}};
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (any && in_ready) begin
                        sel_q <= win;
                        s_ready_q <= {{(N-1){1'b0}}, 1'b1} << win;
                        state_q <= ST_GRANT;
                    end
                end
                ST_GRANT: begin
                    if (s_valid[sel_q]) begin
                        s_ready_q <= {N{1'b0}};
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                    s_ready_q <= {N{1'b0}};
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // Region decode
    // --------------------------------------------------------------
    wire [AW-1:0] g_addr;
    wire [3:0] g_region;
    assign g_addr = s_addr[sel_q*AW +: AW];
    // Taken from bits at or above the page boundary, so the whole of a
    // 4 KB page shares one value; a disabled decode gives the default.
    // The mask folds unimplemented regions onto implemented ones.
    assign g_region = ctrl_q[`AXA_CTRL_REGION_BIT] ?
        (g_addr[REGION_LSB +: 4] & rmask_q) :
        `AXA_REGION_DEFAULT;

    // --------------------------------------------------------------
    // Splitter and piece count
    // --------------------------------------------------------------
    wire [ATTR_W-1:0] g_attr;
    assign g_attr = {s_id[sel_q*IDW +: IDW], s_lock[sel_q],
        s_cache[sel_q*4 +: 4], s_prot[sel_q*3 +: 3],
        s_qos[sel_q*4 +: 4], g_region};

    axa_splitter #(
        .AW(AW),
        .ATTR_W(ATTR_W)
    ) u_split (
        .clk(clk),
        .srst(srst),
        .split_en(ctrl_q[`AXA_CTRL_SPLIT_BIT]),
        .in_valid(take),
        .in_ready(in_ready),
        .in_addr(g_addr),
        .in_len(s_len[sel_q*8 +: 8]),
        .in_size(s_size[sel_q*3 +: 3]),
        .in_burst(s_burst[sel_q*2 +: 2]),
        .in_attr(g_attr),
        .m_valid_q(m_valid),
        .m_ready(m_ready),
        .m_addr_q(m_addr),
        .m_len_q(m_len),
        .m_size_q(m_size),
        .m_burst_q(m_burst),
        .m_attr_q(out_attr),
        .m_last_q(m_last_piece),
        .busy_q(busy)
    );

    // Responses for pieces return in issue order on one ID
    assign {m_id, m_lock, m_cache, m_prot, m_qos, m_region} = out_attr;

    always @(posedge clk) begin
        if (srst) begin
            pieces_q <= 16'h0;
        end else if (m_valid && m_ready) begin
            pieces_q <= pieces_q + 16'h1;
        end
    end

endmodule // axa_channel

// *** verification/axa_channel_assertions.sv ***
// Concurrent checks on the address channel ports.
`timescale 1ns/1ps
module axa_channel_chk #(
    parameter N = 2,
    parameter AW = 32,
    parameter IDW = 4
) (
    input wire clk, // Clock
    input wire srst, // Reset
    input wire [N-1:0] s_valid, // Requests
    input wire [N-1:0] s_ready_q, // Grants
    input wire [N*4-1:0] s_qos, // Request QoS
    input wire m_valid, // Piece valid
    input wire m_ready, // Slave ready
    input wire [AW-1:0] m_addr, // Piece address
    input wire [7:0] m_len, // Piece length
    input wire [2:0] m_size, // Piece size
    input wire [1:0] m_burst, // Piece type
    input wire [3:0] m_qos, // Piece QoS
    input wire [IDW-1:0] m_id, // Piece ID
    input wire [3:0] m_region, // Piece region
    input wire m_last_piece, // Final piece
    input wire avs_read, // Bus read
    input wire avs_write, // Bus write
    input wire avs_waitrequest_q // Bus wait
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire mid = m_valid && m_ready && !m_last_piece;
    hold_piece_a: assert property (m_valid && !m_ready |=> m_valid
        && $stable(m_addr) && $stable(m_len)) else $error("piece changed");
    full_piece_a: assert property (m_valid && !m_last_piece |->
        m_len == 8'h0f) else $error("short inner piece");
    next_addr_a: assert property (mid |=> m_valid && m_addr ==
        $past(m_addr) + ({{(AW-8){1'b0}}, 8'h10} << $past(m_size)))
        else $error("piece address step");
    keep_attr_a: assert property (mid |=> $stable(m_qos)
        && $stable(m_id) && $stable(m_size) && $stable(m_burst))
        else $error("piece attributes changed");
    keep_region_a: assert property (mid |=> $stable(m_region))
        else $error("region changed in burst");
    short_type_a: assert property (m_valid && m_burst != 2'h1
        |-> m_last_piece) else $error("non-incr burst split");
    one_grant_a: assert property ($onehot0(s_ready_q))
        else $error("two grants");
    qos_order_a: assert property ($rose(|s_ready_q) &&
        $past(s_valid) == 2'b11 |-> s_ready_q[1] ==
        ($past(s_qos[7:4]) > $past(s_qos[3:0]))) else $error("qos order");
    wait_pulse_a: assert property ((avs_read || avs_write) &&
        avs_waitrequest_q |=> !avs_waitrequest_q ##1 avs_waitrequest_q)
        else $error("bus answer timing");
endmodule // axa_channel_chk

bind axa_channel axa_channel_chk #(.N(N), .AW(AW), .IDW(IDW)) u_chk (
    .clk, .srst, .s_valid, .s_ready_q, .s_qos, .m_valid, .m_ready,
    .m_addr, .m_len, .m_size, .m_burst, .m_qos, .m_id, .m_region,
    .m_last_piece, .avs_read, .avs_write, .avs_waitrequest_q);

// *** verification/axa_slave_model.sv ***
// Slave-side partner: takes address pieces, optionally stalling.
`timescale 1ns/1ps
module axa_slave_model (
    input wire clk, // Clock
    input wire srst, // Reset
    input wire m_valid, // Piece offered
    input wire stall, // Throttle acceptance
    output wire m_ready // Piece accepted
);
    reg [1:0] cnt_q;
    always @(posedge clk) begin
        if (srst) cnt_q <= 2'h0;
        else cnt_q <= cnt_q + {1'b0, m_valid};
    end
    // Any length, type or region is taken as is; stalling only slows it
    assign m_ready = !stall || cnt_q == 2'h3;
endmodule // axa_slave_model

// *** verification/axa_channel_tb.sv ***
// Self-checking bench for the address channel.
`timescale 1ns/1ps
`include "axaddr_defs.vh"
module axa_channel_tb;
    logic clk = 0, srst = 1, stall = 0, avs_read = 0, avs_write = 0;
    logic [1:0] s_valid = 0;
    logic [63:0] s_addr = 0;
    logic [15:0] s_len = 0;
    logic [5:0] s_size = 0;
    logic [3:0] s_burst = 0, avs_address = 0;
    logic [7:0] s_qos = 0, s_id = 0;
    logic [31:0] avs_writedata = 0, rd;
    wire [1:0] s_ready_q, m_burst;
    wire m_valid, m_ready, m_lock, m_last_piece, avs_waitrequest_q;
    wire [31:0] m_addr, avs_readdata_q;
    wire [7:0] m_len;
    wire [2:0] m_size, m_prot;
    wire [3:0] m_cache, m_qos, m_region, m_id;
    logic [52:0] pq[$], p;
    logic [45:0] rows [6] = '{{32'h100, 8'h27, 2'h1, 3'h2, 1'b0},
        {32'h0, 8'hff, 2'h1, 3'h0, 1'b1}, {32'h2000, 8'h0f, 2'h1, 3'h3, 1'b0},
        {32'h3000, 8'h0f, 2'h2, 3'h2, 1'b1}, {32'h4000, 8'h05, 2'h0, 3'h2, 1'b0},
        {32'h5000, 8'h10, 2'h1, 3'h1, 1'b1}};
    logic [3:0] ra [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h1};
    logic [31:0] rv [5] = '{32'h1, 32'hf, 32'h0, 32'h0, 32'h0};
    logic [7:0] qp [4] = '{8'h93, 8'h55, 8'h00, 8'h39};
    int errors = 0, num_checks = 0, tot = 0;
    always #5 clk = ~clk;
    axa_channel uut (.clk, .srst, .s_valid, .s_ready_q, .s_addr, .s_len,
        // No exclusive accesses are offered, so long bursts stay legal
        .s_size, .s_burst, .s_lock(2'h0), .s_cache(8'h0), .s_prot(6'h0),
        .s_qos, .s_id, .m_valid, .m_ready, .m_addr, .m_len, .m_size,
        .m_burst, .m_lock, .m_cache, .m_prot, .m_qos, .m_region, .m_id,
        .m_last_piece, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata_q, .avs_waitrequest_q);
    axa_slave_model u_slv (.clk, .srst, .m_valid, .stall, .m_ready);
    always @(posedge clk) begin
        if (m_valid && m_ready) pq.push_back({m_id, m_last_piece, m_region,
            m_qos, m_len, m_addr});
    end
    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic give_up;
        errors++;
        report_and_stop;
    endtask
    // Holds the request until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (avs_waitrequest_q === 1'b0) break;
        end
        r = avs_readdata_q;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k == 50) give_up;
    endtask
    task automatic load(input int i, input logic [31:0] a,
        input logic [7:0] l, input logic [1:0] b, input logic [2:0] z,
        input logic [3:0] q);
        s_addr[i*32+:32] <= a;
        s_len[i*8+:8] <= l;
        s_burst[i*2+:2] <= b;
        s_size[i*3+:3] <= z;
        s_qos[i*4+:4] <= q;
        s_id[i*4+:4] <= i[3:0];
        s_valid[i] <= 1'b1;
    endtask
    task automatic accept_all(input int n);
        int k;
        for (k = 0; k < 300; k++) begin
            @(posedge clk);
            if (s_valid == 2'h0) break;
            s_valid <= s_valid & ~s_ready_q;
        end
        for (k = k; k < 600 && pq.size() < n; k++) @(posedge clk);
        if (pq.size() < n) give_up;
        tot += n;
    endtask
    task automatic run_row(input logic [31:0] a, input logic [7:0] l,
        input logic [1:0] b, input logic [2:0] z, input logic sp,
        input logic [3:0] rg);
        int np;
        logic [31:0] ea;
        np = (sp && b == `AXA_BURST_INCR && l > 8'h0f) ? l / 16 + 1 : 1;
        ea = a;
        load(0, a, l, b, z, 4'h0);
        accept_all(np);
        for (int k = 0; k < np; k++) begin
            p = pq.pop_front();
            check("piece_addr", p[31:0], ea);
            check("piece_len", p[39:32], k < np - 1 ? 8'h0f :
                l - 8'(16 * (np - 1)));
            check("piece_last", p[48], k == np - 1);
            check("piece_region", p[47:44], rg);
            ea = ea + (32'h10 << z);
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        for (int r = 0; r < 2; r++) begin
            for (int k = 0; k < 5; k++) begin
                bus(1'b0, ra[k], 32'h0, rd);
                check("reg_value", rd, rv[k]);
            end
            bus(1'b1, `AXA_OFS_STATUS, 32'h3, rd);
            bus(1'b1, `AXA_OFS_PIECES, 32'hffff, rd);
            bus(1'b1, 4'h1, 32'hf, rd);
        end
        for (int k = 0; k < 6; k++) begin
            stall <= rows[k][0];
            run_row(rows[k][45:14], rows[k][13:6], rows[k][5:4],
                rows[k][3:1], 1'b1, 4'h0);
        end
        bus(1'b1, `AXA_OFS_CTRL, 32'h0, rd);
        run_row(32'h100, 8'h27, 2'h1, 3'h2, 1'b0, 4'h0);
        bus(1'b1, `AXA_OFS_CTRL, 32'h3, rd);
        bus(1'b1, `AXA_OFS_RMASK, 32'hfffffff3, rd);
        bus(1'b0, `AXA_OFS_RMASK, 32'h0, rd);
        check("rmask", rd, 32'h3);
        run_row(32'hd0000040, 8'h1f, 2'h1, 3'h2, 1'b1, 4'h1);
        bus(1'b0, `AXA_OFS_PIECES, 32'h0, rd);
        check("pieces", rd, tot);
        for (int k = 0; k < 4; k++) begin
            load(0, 32'h1000, 8'h0, 2'h1, 3'h2, qp[k][3:0]);
            load(1, 32'h2000, 8'h0, 2'h1, 3'h2, qp[k][7:4]);
            accept_all(2);
            p = pq.pop_front();
            check("first_addr", p[31:0], qp[k][7:4] > qp[k][3:0] ?
                32'h2000 : 32'h1000);
            check("first_id", p[52:49], qp[k][7:4] > qp[k][3:0] ?
                32'h1 : 32'h0);
            p = pq.pop_front();
            check("second_qos", p[43:40], qp[k][7:4] > qp[k][3:0] ?
                qp[k][3:0] : qp[k][7:4]);
        end
        load(0, 32'h0, 8'hff, 2'h1, 3'h0, 4'h0);
        accept_all(1);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        check("valid_in_reset", m_valid, 1'b0);
        srst <= 1'b0;
        bus(1'b0, `AXA_OFS_CTRL, 32'h0, rd);
        check("ctrl_after_reset", rd, 32'h1);
        report_and_stop;
    end
endmodule // axa_channel_tb
